// File: core/bsrc_defs.vh
// Constants for the boot source and reset controller.
`ifndef BSRC_DEFS_VH
`define BSRC_DEFS_VH

// System clock period in ns (10 MHz).
`define BSRC_CLK_NS 100

// Strap settle time per pull phase, least time, in ns.
`define BSRC_SETTLE_NS 1000
`define BSRC_SETTLE_CYC ((`BSRC_SETTLE_NS + `BSRC_CLK_NS - 1) / `BSRC_CLK_NS)

// Internal hold time of a whole-device soft reset, least time, in ns.
`define BSRC_WDR_NS 800
`define BSRC_WDR_CYC ((`BSRC_WDR_NS + `BSRC_CLK_NS - 1) / `BSRC_CLK_NS)

// Processor hold time of a processor-only soft reset, least time, in ns.
`define BSRC_CPUR_NS 400
`define BSRC_CPUR_CYC ((`BSRC_CPUR_NS + `BSRC_CLK_NS - 1) / `BSRC_CLK_NS)

// Per-pin strap level codes: {floating, high}.
`define BSRC_PIN_LO 2'h0
`define BSRC_PIN_HI 2'h1
`define BSRC_PIN_FL 2'h2

// Strap codes, pin 2 in the top pair, pin 0 in the bottom pair.
`define BSRC_STRAP_F00 6'h20
`define BSRC_STRAP_F01 6'h21
`define BSRC_STRAP_F11 6'h25
`define BSRC_STRAP_F0F 6'h22
`define BSRC_STRAP_F1F 6'h26
`define BSRC_STRAP_1FF 6'h1A
`define BSRC_STRAP_0F1 6'h09

// Boot source codes on O_BOOT_SRC.
`define BSRC_SRC_SYNC_ADDRESS_DATA_MULTIPLEXED 3'h0
`define BSRC_SRC_ASYNC_ADDRESS_DATA_MULTIPLEXED 3'h1
`define BSRC_SRC_ASYNC_SRAM 3'h2
`define BSRC_SRC_I2C 3'h3
`define BSRC_SRC_SPI 3'h4
`define BSRC_SRC_USB 3'h5
`define BSRC_SRC_NONE 3'h7

`endif

// File: core/bsrc_sync.v
// Two-flip-flop synchroniser for pin inputs.
`timescale 1ns/100ps
module bsrc_sync #(
    parameter WIDTH = 1,
    parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
    input wire i_clk,
    input wire i_srst,
    input wire [WIDTH-1:0] i_async,
    output wire [WIDTH-1:0] o_sync
);
    reg [WIDTH-1:0] meta;
    reg [WIDTH-1:0] stable;

    always @(posedge i_clk) begin
        if (i_srst) begin
            meta <= INIT;
            stable <= INIT;
        end else begin
            meta <= i_async;
            stable <= meta;
        end
    end

    assign o_sync = stable;
endmodule

// File: core/bsrc_top.v
// Boot source selection from the strap pins and hard/soft reset sequencing.
//
// What this block does
// - Strap code F11 selects loading the boot image over USB.
// - Strap code F00 boots through the parallel host port in synchronous 16-bit mux mode.
// - Strap code F01 boots through the parallel host port in asynchronous 16-bit mux mode.
// - Strap code F0F boots through the parallel host port in asynchronous 16-bit SRAM mode.
// - Strap code F1F tries I2C first and falls back to USB if that load fails.
// - Strap code 1FF boots only from an I2C EEPROM as master, with no USB fallback.
// - Strap code 0F1 tries SPI flash first and falls back to USB if that load fails.
// - All I/O pins stay high impedance for as long as a hard reset is active.
// - After hard reset the boot loader takes over and sets up I/O for the chosen source.
// - Soft resets come from the processor writing reset bits of the init control register.
// - A processor-only soft reset restarts the processor but keeps the loaded firmware.
// - A whole-device soft reset acts like a hard reset and the firmware must be reloaded.
`timescale 1ns/100ps
`include "bsrc_defs.vh"
module bsrc_top (
    input wire I_SYS_CLK,
    input wire I_SRST,
    input wire I_RESET_N,
    input wire [2:0] I_STRAP,
    input wire I_CPU_SOFT_RST_REQ,
    input wire I_DEV_SOFT_RST_REQ,
    input wire I_LOAD_DONE,
    input wire I_LOAD_FAIL,
    output wire [2:0] O_STRAP_PU_EN,
    output wire [2:0] O_STRAP_PD_EN,
    output wire O_IO_HIZ,
    output wire O_CPU_RESET,
    output wire O_LOAD_START,
    output wire [2:0] O_BOOT_SRC,
    output wire O_FALLBACK_USED,
    output wire O_FW_LOADED,
    output wire O_BOOT_ERROR
);
    localparam [2:0] ST_HOLD = 3'h0;
    localparam [2:0] ST_PULL_UP = 3'h1;
    localparam [2:0] ST_PULL_DN = 3'h2;
    localparam [2:0] ST_DECODE = 3'h3;
    localparam [2:0] ST_LOAD = 3'h4;
    localparam [2:0] ST_RUN = 3'h5;
    localparam [2:0] ST_CPU_RST = 3'h6;
    localparam [2:0] ST_FAIL = 3'h7;

    localparam [31:0] SETTLE_FULL = `BSRC_SETTLE_CYC;
    localparam [31:0] WDR_FULL = `BSRC_WDR_CYC;
    localparam [31:0] CPUR_FULL = `BSRC_CPUR_CYC;
    localparam [3:0] SETTLE_CYC = SETTLE_FULL[3:0];
    localparam [3:0] WDR_CYC = WDR_FULL[3:0];
    localparam [3:0] CPUR_CYC = CPUR_FULL[3:0];

    wire reset_n_sync;
    wire [2:0] strap_sync;
    wire hard_rst;

    reg [2:0] state;
    reg [3:0] cnt;
    reg [3:0] hold_cnt;
    reg [2:0] up_smp;
    reg [2:0] dn_smp;
    reg [2:0] boot_src;
    reg allow_fallback;
    reg fallback_used;
    reg fw_loaded;
    reg io_hiz;
    reg cpu_reset;
    reg load_start;
    reg [2:0] pu_en;
    reg [2:0] pd_en;
    reg boot_error;

    reg [5:0] strap_code;
    reg [2:0] next_src;
    reg next_fallback;
    integer i;

    bsrc_sync #(
        .WIDTH(1),
        .INIT(1'b0)
    ) u_reset_sync (
        .i_clk(I_SYS_CLK),
        .i_srst(I_SRST),
        .i_async(I_RESET_N),
        .o_sync(reset_n_sync)
    );

    bsrc_sync #(
        .WIDTH(3),
        .INIT(3'h0)
    ) u_strap_sync (
        .i_clk(I_SYS_CLK),
        .i_srst(I_SRST),
        .i_async(I_STRAP),
        .o_sync(strap_sync)
    );

    // Hard reset is the low level of the reset pin.
    assign hard_rst = ~reset_n_sync;

    // A pin whose pull-up and pull-down samples differ is floating; otherwise it is tied.
    always @* begin
        strap_code = 6'h00;
        for (i = 0; i < 3; i = i + 1) begin
            if (up_smp[i] != dn_smp[i]) begin
                strap_code[2*i +: 2] = `BSRC_PIN_FL;
            end else if (up_smp[i]) begin
                strap_code[2*i +: 2] = `BSRC_PIN_HI;
            end else begin
                strap_code[2*i +: 2] = `BSRC_PIN_LO;
            end
        end
    end

    // Strap code to boot source, with the USB fallback permission.
    always @* begin
        next_src = `BSRC_SRC_NONE;
        next_fallback = 1'b0;
        case (strap_code)
            `BSRC_STRAP_F00: begin
                next_src = `BSRC_SRC_SYNC_ADDRESS_DATA_MULTIPLEXED;
            end
            `BSRC_STRAP_F01: begin
                next_src = `BSRC_SRC_ASYNC_ADDRESS_DATA_MULTIPLEXED;
            end
            `BSRC_STRAP_F11: begin
                next_src = `BSRC_SRC_USB;
            end
            `BSRC_STRAP_F0F: begin
                next_src = `BSRC_SRC_ASYNC_SRAM;
            end
            `BSRC_STRAP_F1F: begin
                next_src = `BSRC_SRC_I2C;
                next_fallback = 1'b1;
            end
            `BSRC_STRAP_1FF: begin
                next_src = `BSRC_SRC_I2C;
                next_fallback = 1'b0;
            end
            `BSRC_STRAP_0F1: begin
                next_src = `BSRC_SRC_SPI;
                next_fallback = 1'b1;
            end
            default: begin
                next_src = `BSRC_SRC_NONE;
                next_fallback = 1'b0;
            end
        endcase
    end

    always @(posedge I_SYS_CLK) begin
        if (I_SRST) begin
            state <= ST_HOLD;
            cnt <= 4'h0;
            hold_cnt <= 4'h0;
            up_smp <= 3'h0;
            dn_smp <= 3'h0;
            boot_src <= `BSRC_SRC_NONE;
            allow_fallback <= 1'b0;
            fallback_used <= 1'b0;
            fw_loaded <= 1'b0;
            io_hiz <= 1'b1;
            cpu_reset <= 1'b1;
            load_start <= 1'b0;
            pu_en <= 3'h0;
            pd_en <= 3'h0;
            boot_error <= 1'b0;
        end else begin
            load_start <= 1'b0;
            if (hard_rst) begin
                state <= ST_HOLD;
                hold_cnt <= 4'h0;
                io_hiz <= 1'b1;
                cpu_reset <= 1'b1;
                fw_loaded <= 1'b0;
                pu_en <= 3'h0;
                pd_en <= 3'h0;
                boot_error <= 1'b0;
            end else begin
                case (state)
                    ST_HOLD: begin
                        if (hold_cnt != 4'h0) begin
                            hold_cnt <= hold_cnt - 4'h1;
                        end else begin
                            // Sampling starts only at release of the reset.
                            state <= ST_PULL_UP;
                            cnt <= SETTLE_CYC;
                            pu_en <= 3'h7;
                        end
                    end
                    ST_PULL_UP: begin
                        if (cnt != 4'h0) begin
                            cnt <= cnt - 4'h1;
                        end else begin
                            up_smp <= strap_sync;
                            pu_en <= 3'h0;
                            pd_en <= 3'h7;
                            cnt <= SETTLE_CYC;
                            state <= ST_PULL_DN;
                        end
                    end
                    ST_PULL_DN: begin
                        if (cnt != 4'h0) begin
                            cnt <= cnt - 4'h1;
                        end else begin
                            dn_smp <= strap_sync;
                            pd_en <= 3'h0;
                            state <= ST_DECODE;
                        end
                    end
                    ST_DECODE: begin
                        // The decoded source is held until a USB fallback or the next reset.
                        boot_src <= next_src;
                        allow_fallback <= next_fallback;
                        fallback_used <= 1'b0;
                        if (next_src == `BSRC_SRC_NONE) begin
                            state <= ST_FAIL;
                            boot_error <= 1'b1;
                        end else begin
                            io_hiz <= 1'b0;
                            load_start <= 1'b1;
                            state <= ST_LOAD;
                        end
                    end
                    ST_LOAD: begin
                        if (I_LOAD_DONE) begin
                            fw_loaded <= 1'b1;
                            cpu_reset <= 1'b0;
                            state <= ST_RUN;
                        end else if (I_LOAD_FAIL) begin
                            if (allow_fallback && boot_src != `BSRC_SRC_USB) begin
                                boot_src <= `BSRC_SRC_USB;
                                fallback_used <= 1'b1;
                                load_start <= 1'b1;
                            end else begin
                                state <= ST_FAIL;
                                boot_error <= 1'b1;
                            end
                        end
                    end
                    ST_RUN: begin
                        if (I_DEV_SOFT_RST_REQ) begin
                            // Same path as a hard reset, for a fixed hold time.
                            state <= ST_HOLD;
                            hold_cnt <= WDR_CYC;
                            io_hiz <= 1'b1;
                            cpu_reset <= 1'b1;
                            fw_loaded <= 1'b0;
                        end else if (I_CPU_SOFT_RST_REQ) begin
                            state <= ST_CPU_RST;
                            cnt <= CPUR_CYC;
                            cpu_reset <= 1'b1;
                        end
                    end
                    ST_CPU_RST: begin
                        if (cnt != 4'h0) begin
                            cnt <= cnt - 4'h1;
                        end else begin
                            // Firmware stays loaded, so the processor restarts directly.
                            cpu_reset <= 1'b0;
                            state <= ST_RUN;
                        end
                    end
                    ST_FAIL: begin
                        cpu_reset <= 1'b1;
                    end
                    default: begin
                        state <= ST_HOLD;
                    end
                endcase
            end
        end
    end

    assign O_STRAP_PU_EN = pu_en;
    assign O_STRAP_PD_EN = pd_en;
    assign O_IO_HIZ = io_hiz;
    assign O_CPU_RESET = cpu_reset;
    assign O_LOAD_START = load_start;
    assign O_BOOT_SRC = boot_src;
    assign O_FALLBACK_USED = fallback_used;
    assign O_FW_LOADED = fw_loaded;
    assign O_BOOT_ERROR = boot_error;
endmodule

// File: tb/bsrc_far.sv
// Model of the strap resistors and the boot image loader.
`timescale 1ns/100ps
module bsrc_far (
    input wire clk,
    input wire [5:0] i_cfg,
    input wire [1:0] i_mode,
    input wire [3:0] i_lat,
    input wire [2:0] i_pu_en,
    input wire [2:0] i_pd_en,
    input wire i_load_start,
    input wire [2:0] i_boot_src,
    output reg [2:0] o_strap,
    output reg o_done = 1'b0,
    output reg o_fail = 1'b0
);
    reg [2:0] drift = 3'h0;
    reg [3:0] cnt = 4'h0;
    reg busy = 1'b0;
    reg [2:0] src = 3'h0;
    integer n;
    // A floating pin follows the enabled pull and wanders when none is on.
    always @* begin
        for (n = 0; n < 3; n = n + 1) begin
            o_strap[n] = i_cfg[2*n+1] ? (i_pu_en[n] | (~i_pd_en[n] & drift[n])) : i_cfg[2*n];
        end
    end
    always @(posedge clk) begin
        drift <= ~drift;
        o_done <= 1'b0;
        o_fail <= 1'b0;
        if (i_load_start) begin
            busy <= 1'b1;
            cnt <= i_lat;
            src <= i_boot_src;
        end else if (busy && cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
        end else if (busy) begin
            busy <= 1'b0;
            o_fail <= i_mode == 2'h2 || (i_mode == 2'h1 && src != 3'h5);
            o_done <= !(i_mode == 2'h2 || (i_mode == 2'h1 && src != 3'h5));
        end
    end
endmodule

// File: tb/bsrc_monitor.sv
// Port checker for the boot source and reset controller.
`timescale 1ns/100ps
module bsrc_monitor (
    input wire I_SYS_CLK,
    input wire I_SRST,
    input wire I_RESET_N,
    input wire I_CPU_SOFT_RST_REQ,
    input wire I_DEV_SOFT_RST_REQ,
    input wire [2:0] O_STRAP_PU_EN,
    input wire [2:0] O_STRAP_PD_EN,
    input wire O_IO_HIZ,
    input wire O_CPU_RESET,
    input wire O_LOAD_START,
    input wire [2:0] O_BOOT_SRC,
    input wire O_FALLBACK_USED,
    input wire O_FW_LOADED,
    input wire O_BOOT_ERROR
);
    default clocking @(posedge I_SYS_CLK); endclocking
    default disable iff (I_SRST);
    wire run = O_FW_LOADED && !O_CPU_RESET && !O_IO_HIZ && I_RESET_N;
    sequence up_phase;
        (O_STRAP_PU_EN == 3'h7)[*8] ##1 (O_STRAP_PU_EN == 3'h7)[*3];
    endsequence
    sequence dn_phase;
        (O_STRAP_PU_EN == 3'h0 && O_STRAP_PD_EN == 3'h7)[*8] ##1 (O_STRAP_PD_EN == 3'h7)[*3];
    endsequence
    a_hiz_in_reset: assert property (!I_RESET_N [*4] |-> O_IO_HIZ && O_CPU_RESET && !O_FW_LOADED)
        else $error("io or cpu not held in hard reset");
    a_pull_only_hiz: assert property ((|O_STRAP_PU_EN || |O_STRAP_PD_EN) |-> O_IO_HIZ)
        else $error("strap pulls on while io driven");
    a_strap_sample_order: assert property ($rose(O_STRAP_PU_EN[0]) |-> up_phase ##1 dn_phase
        ##1 (O_STRAP_PD_EN == 3'h0) ##1 (O_LOAD_START || O_BOOT_ERROR))
        else $error("strap sampling sequence wrong");
    a_start_one_pulse: assert property (O_LOAD_START |-> !O_IO_HIZ && O_BOOT_SRC != 3'h7 ##1 !O_LOAD_START)
        else $error("load start malformed");
    a_src_held: assert property (!$stable(O_BOOT_SRC) |-> O_LOAD_START || O_BOOT_SRC == 3'h7)
        else $error("boot source changed without a load");
    a_cpu_soft_len: assert property (run && I_CPU_SOFT_RST_REQ && !I_DEV_SOFT_RST_REQ
        |=> (O_CPU_RESET && O_FW_LOADED)[*5] ##1 !O_CPU_RESET)
        else $error("processor soft reset length wrong");
    a_dev_soft_reset: assert property (run && I_DEV_SOFT_RST_REQ |=> O_IO_HIZ && O_CPU_RESET && !O_FW_LOADED)
        else $error("whole device soft reset not applied");
    a_fallback_usb: assert property ($rose(O_FALLBACK_USED) |-> O_BOOT_SRC == 3'h5 && O_LOAD_START)
        else $error("fallback not to usb");
    a_loaded_run: assert property ($rose(O_FW_LOADED) |-> !O_CPU_RESET && !O_IO_HIZ && !O_BOOT_ERROR)
        else $error("firmware loaded but processor held");
endmodule

bind bsrc_top bsrc_monitor mon (.I_SYS_CLK, .I_SRST, .I_RESET_N, .I_CPU_SOFT_RST_REQ,
    .I_DEV_SOFT_RST_REQ, .O_STRAP_PU_EN, .O_STRAP_PD_EN, .O_IO_HIZ, .O_CPU_RESET,
    .O_LOAD_START, .O_BOOT_SRC, .O_FALLBACK_USED, .O_FW_LOADED, .O_BOOT_ERROR);

// File: tb/test_bsrc_top.sv
// Self-checking bench for the boot source and reset controller.
`timescale 1ns/100ps
`include "bsrc_defs.vh"
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin err_count++; \
    $display("CHECK FAILED %s exp %h got %h", n, e, a); end end
module test_bsrc_top;
    reg clk = 1'b0;
    reg srst = 1'b1;
    reg rst_n = 1'b0;
    reg cpu_req = 1'b0;
    reg dev_req = 1'b0;
    reg [5:0] cfg = `BSRC_STRAP_F11;
    reg [1:0] mode = 2'h0;
    reg [3:0] lat = 4'h1;
    wire [2:0] strap, pu, pd, src;
    wire done, fail, hiz, cpu_rst, start, fb, loaded, berr;
    int err_count = 0;
    int comparisons = 0;
    int k;
    always #50 clk = ~clk;
    bsrc_top dut (.I_SYS_CLK(clk), .I_SRST(srst), .I_RESET_N(rst_n), .I_STRAP(strap),
        .I_CPU_SOFT_RST_REQ(cpu_req), .I_DEV_SOFT_RST_REQ(dev_req), .I_LOAD_DONE(done),
        .I_LOAD_FAIL(fail), .O_STRAP_PU_EN(pu), .O_STRAP_PD_EN(pd), .O_IO_HIZ(hiz),
        .O_CPU_RESET(cpu_rst), .O_LOAD_START(start), .O_BOOT_SRC(src),
        .O_FALLBACK_USED(fb), .O_FW_LOADED(loaded), .O_BOOT_ERROR(berr));
    bsrc_far far (.clk(clk), .i_cfg(cfg), .i_mode(mode), .i_lat(lat), .i_pu_en(pu),
        .i_pd_en(pd), .i_load_start(start), .i_boot_src(src), .o_strap(strap),
        .o_done(done), .o_fail(fail));
    task tally_and_finish;
        if (err_count == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task pulse(input bit dev);
        if (dev) begin
            dev_req = 1'b1;
        end else begin
            cpu_req = 1'b1;
        end
        @(negedge clk);
        cpu_req = 1'b0;
        dev_req = 1'b0;
        @(negedge clk);
    endtask
    task wait_start;
        for (k = 0; k < 60 && !start && !berr; k++) @(negedge clk);
    endtask
    task wait_end;
        for (k = 0; k < 90 && !loaded && !berr; k++) @(negedge clk);
    endtask
    task hard_boot(input [5:0] c, input [1:0] m);
        @(negedge clk);
        rst_n = 1'b0;
        cfg = c;
        mode = m;
        repeat (4) @(negedge clk);
        `CHK("hiz", 1'b1, hiz)
        rst_n = 1'b1;
        wait_start();
    endtask
    task s_boot(input [5:0] c, input [2:0] s, input [1:0] m, input [3:0] l);
        lat = l;
        hard_boot(c, m);
        `CHK("src", s, src)
        wait_end();
        `CHK("fallback", m[0], fb)
        `CHK("src_end", m[0] ? `BSRC_SRC_USB : s, src)
        `CHK("loaded", 1'b1, loaded)
        `CHK("cpu_rst", 1'b0, cpu_rst)
    endtask
    task s_errors;
        hard_boot(`BSRC_STRAP_1FF, 2'h1);
        wait_end();
        `CHK("i2c_only", 2'h2, {berr, fb})
        hard_boot(`BSRC_STRAP_F1F, 2'h2);
        wait_end();
        `CHK("usb_fail", 3'h6, {berr, fb, loaded})
        hard_boot(6'h00, 2'h0);
        `CHK("unknown", 4'hF, {berr, src})
    endtask
    task s_soft;
        s_boot(`BSRC_STRAP_F00, `BSRC_SRC_SYNC_ADDRESS_DATA_MULTIPLEXED, 2'h0, 4'h6);
        pulse(1'b0);
        `CHK("cpu_hold", 1'b1, cpu_rst)
        repeat (5) @(negedge clk);
        `CHK("cpu_free", 2'h1, {cpu_rst, loaded})
        cfg = `BSRC_STRAP_0F1;
        repeat (30) @(negedge clk);
        `CHK("src_held", `BSRC_SRC_SYNC_ADDRESS_DATA_MULTIPLEXED, src)
        pulse(1'b1);
        `CHK("dev_rst", 2'h2, {hiz, loaded})
        wait_start();
        `CHK("resample", `BSRC_SRC_SPI, src)
        wait_end();
        `CHK("reload", 1'b1, loaded)
    endtask
    initial begin
        repeat (5) @(negedge clk);
        srst = 1'b0;
        s_boot(`BSRC_STRAP_F11, `BSRC_SRC_USB, 2'h0, 4'h1);
        s_boot(`BSRC_STRAP_F00, `BSRC_SRC_SYNC_ADDRESS_DATA_MULTIPLEXED, 2'h0, 4'h1);
        s_boot(`BSRC_STRAP_F01, `BSRC_SRC_ASYNC_ADDRESS_DATA_MULTIPLEXED, 2'h0, 4'h6);
        s_boot(`BSRC_STRAP_F0F, `BSRC_SRC_ASYNC_SRAM, 2'h0, 4'h1);
        s_boot(`BSRC_STRAP_F1F, `BSRC_SRC_I2C, 2'h1, 4'h6);
        s_boot(`BSRC_STRAP_1FF, `BSRC_SRC_I2C, 2'h0, 4'h1);
        s_boot(`BSRC_STRAP_0F1, `BSRC_SRC_SPI, 2'h1, 4'h1);
        s_errors();
        s_soft();
        tally_and_finish();
    end
    initial begin
        #400000;
        err_count++;
        tally_and_finish();
    end
endmodule
